// ---- design/epw_core.v ----
`timescale 1ns/1ns
`include "epw_map.vh"

module epw_core #(
    parameter WRITE_CYCLES = (`EPW_T_WRITE_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS
) (
    input  wire clk,
    input  wire rst,
    input  wire nv_rst,
    input  wire cs_n,
    input  wire sck,
    input  wire si,
    input  wire wp_n,
    output wire so,
    output wire so_oe_n,
    output wire standby,
    output wire write_enable_latch,
    output wire write_in_progress,
    output wire protect_level_high_bit,
    output wire protect_level_low_bit
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam ST_CMD   = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_WDATA = 3'h2;
    localparam ST_RDATA = 3'h3;
    localparam ST_RSR   = 3'h4;
    localparam ST_WSR   = 3'h5;
    localparam ST_END   = 3'h6;
    localparam ST_IGN   = 3'h7;

    localparam END_SETL = 2'h0;
    localparam END_CLRL = 2'h1;
    localparam END_STAT = 2'h2;

    localparam integer         WC_LAST_I = WRITE_CYCLES - 1;
    localparam [`EPW_WC_W-1:0] WC_LAST   = WC_LAST_I[`EPW_WC_W-1:0];

    reg  [2:0]          st_q;
    reg  [1:0]          end_op_q;
    reg                 sck_q;
    reg                 cs_q;
    reg  [2:0]          bit_q;
    reg  [6:0]          sh_q;
    reg                 rd_mode_q;
    reg                 a8_q;
    reg  [`EPW_AW-1:0]  waddr_q;
    reg  [`EPW_PW-1:0]  ptr_q;
    reg  [15:0]         mask_q;
    reg  [`EPW_AW-1:0]  rd_ptr_q;
    reg                 load_pend_q;
    reg  [7:0]          so_sh_q;
    reg  [1:0]          wsr_val_q;
    reg                 latch_q;
    reg                 busy_q;
    reg  [`EPW_WC_W-1:0] wt_q;
    reg                 cp_run_q;
    reg  [4:0]          cp_q;
    reg                 cp_v_q;
    reg  [`EPW_PW-1:0]  cp_idx_q;
    reg  [1:0]          bp_q;

    wire [7:0]          ar_rdata;
    wire [7:0]          pb_rdata;

    // ----------------------------------------------------------------
    // serial front end
    // ----------------------------------------------------------------
    // pins are synchronous to clk, so plain edge detection suffices
    wire       active    = ~cs_n;
    wire       sck_rise  = sck & ~sck_q;
    wire       cs_rise   = cs_n & ~cs_q;
    wire [7:0] rx_byte   = {sh_q, si};
    wire       byte_done = active & sck_rise & (bit_q == `EPW_BIT_LAST);
    wire [7:0] op        = rx_byte & `EPW_OP_MASK;
    wire       whole     = (bit_q == `EPW_BIT_FIRST);
    wire [7:0] status    = {`EPW_SR_UPPER, bp_q, latch_q, busy_q};

    function prot;
        input [1:0]         lvl;
        input [`EPW_AW-1:0] a;
        begin
            case (lvl)
                `EPW_PROT_NONE:  prot = 1'b0;
                `EPW_PROT_QUART: prot = (a >= `EPW_QUART_BASE);
                `EPW_PROT_HALF:  prot = (a >= `EPW_HALF_BASE);
                default:         prot = 1'b1;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // commit conditions, all but wt_end taken on select release
    // ----------------------------------------------------------------
    // boundaries are page aligned, so the start address decides the page
    wire may_write = latch_q & wp_n & ~busy_q;
    wire setl_go   = cs_rise & whole & (st_q == ST_END) & (end_op_q == END_SETL);
    wire clrl_go   = cs_rise & whole & (st_q == ST_END) & (end_op_q == END_CLRL);
    wire stat_go   = cs_rise & whole & (st_q == ST_END) & (end_op_q == END_STAT)
                     & may_write;
    wire write_go  = cs_rise & whole & (st_q == ST_WDATA) & (|mask_q) & may_write
                     & ~prot(bp_q, waddr_q);
    wire wt_end    = busy_q & (wt_q == WC_LAST);

    // ----------------------------------------------------------------
    // memory port steering
    // ----------------------------------------------------------------
    wire rd_first  = byte_done & (st_q == ST_ADDR) & rd_mode_q;
    wire rd_bound  = byte_done & (st_q == ST_RDATA);
    wire ar_re     = rd_first | load_pend_q | rd_bound;
    wire [`EPW_AW-1:0] ar_raddr = rd_first ? {a8_q, rx_byte} : rd_ptr_q + 9'h001;
    wire pb_we     = byte_done & (st_q == ST_WDATA);
    wire ar_we     = cp_v_q & mask_q[cp_idx_q];
    wire [`EPW_AW-1:0] ar_waddr = {waddr_q[`EPW_AW-1:`EPW_PW], cp_idx_q};

    epw_ram #(.AW(`EPW_AW), .DW(`EPW_DW)) u_array (
        .clk     (clk),
        .rst     (rst),
        .we      (ar_we),
        .waddr   (ar_waddr),
        .wdata   (pb_rdata),
        .re      (ar_re),
        .raddr   (ar_raddr),
        .rdata_q (ar_rdata)
    );

    epw_ram #(.AW(`EPW_PW), .DW(`EPW_DW)) u_page (
        .clk     (clk),
        .rst     (rst),
        .we      (pb_we),
        .waddr   (ptr_q),
        .wdata   (rx_byte),
        .re      (cp_run_q),
        .raddr   (cp_q[`EPW_PW-1:0]),
        .rdata_q (pb_rdata)
    );

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q        <= ST_CMD;
            end_op_q    <= END_SETL;
            sck_q       <= 1'b0;
            cs_q        <= 1'b1;
            bit_q       <= `EPW_BIT_FIRST;
            sh_q        <= 7'h00;
            rd_mode_q   <= 1'b0;
            a8_q        <= 1'b0;
            waddr_q     <= 9'h000;
            ptr_q       <= 4'h0;
            mask_q      <= 16'h0000;
            rd_ptr_q    <= 9'h000;
            load_pend_q <= 1'b0;
            so_sh_q     <= 8'h00;
            wsr_val_q   <= `EPW_BP_RESET;
        end else begin
            sck_q       <= sck;
            cs_q        <= cs_n;
            load_pend_q <= rd_first;
            if (!active) begin
                st_q  <= ST_CMD;
                bit_q <= `EPW_BIT_FIRST;
            end else if (sck_rise) begin
                sh_q  <= rx_byte[6:0];
                bit_q <= bit_q + 3'h1;
            end
            if (load_pend_q) begin
                so_sh_q  <= ar_rdata;
                rd_ptr_q <= ar_raddr;
            end else if (active & sck_rise & !byte_done) begin
                so_sh_q <= {so_sh_q[6:0], 1'b0};
            end
            if (byte_done) begin
                case (st_q)
                    ST_CMD: begin
                        a8_q      <= rx_byte[`EPW_A8_BIT];
                        rd_mode_q <= (op == `EPW_OP_READ);
                        case (op)
                            `EPW_OP_READ, `EPW_OP_WRITE: begin
                                st_q <= busy_q ? ST_IGN : ST_ADDR;
                            end
                            `EPW_OP_RDSTAT: begin
                                st_q    <= ST_RSR;
                                so_sh_q <= status;
                            end
                            `EPW_OP_WRSTAT: st_q <= ST_WSR;
                            `EPW_OP_SETL: begin
                                st_q     <= ST_END;
                                end_op_q <= END_SETL;
                            end
                            `EPW_OP_WRDIS: begin
                                st_q     <= ST_END;
                                end_op_q <= END_CLRL;
                            end
                            default: st_q <= ST_IGN;
                        endcase
                        // only read and write carry an address bit in bit 3
                        if ((rx_byte != op) && (op != `EPW_OP_READ) && (op != `EPW_OP_WRITE)) begin
                            st_q <= ST_IGN;
                        end
                    end
                    ST_ADDR: begin
                        waddr_q <= {a8_q, rx_byte};
                        ptr_q   <= rx_byte[`EPW_PW-1:0];
                        if (rd_mode_q) begin
                            st_q     <= ST_RDATA;
                            rd_ptr_q <= {a8_q, rx_byte};
                        end else begin
                            st_q   <= ST_WDATA;
                            mask_q <= 16'h0000;
                        end
                    end
                    ST_WDATA: begin
                        // pointer wraps inside the page
                        ptr_q          <= ptr_q + 4'h1;
                        mask_q[ptr_q]  <= 1'b1;
                    end
                    ST_RDATA: begin
                        so_sh_q  <= ar_rdata;
                        rd_ptr_q <= ar_raddr;
                    end
                    ST_RSR: so_sh_q <= status;
                    ST_WSR: begin
                        wsr_val_q <= rx_byte[`EPW_SR_BP_HI:`EPW_SR_BP_LO];
                        st_q      <= ST_END;
                        end_op_q  <= END_STAT;
                    end
                    default: st_q <= ST_IGN;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // write-enable latch and internal write cycle
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q  <= 1'b0;
            busy_q   <= 1'b0;
            wt_q     <= {`EPW_WC_W{1'b0}};
            cp_run_q <= 1'b0;
            cp_q     <= 5'h00;
            cp_v_q   <= 1'b0;
            cp_idx_q <= 4'h0;
        end else begin
            if (!wp_n) begin
                latch_q <= 1'b0;
            end else if (setl_go) begin
                latch_q <= 1'b1;
            end else if (clrl_go | wt_end) begin
                latch_q <= 1'b0;
            end
            if (write_go | stat_go) begin
                busy_q   <= 1'b1;
                wt_q     <= {`EPW_WC_W{1'b0}};
                cp_run_q <= write_go;
                cp_q     <= 5'h00;
            end else if (busy_q) begin
                wt_q <= wt_q + 20'h00001;
                if (wt_end) begin
                    busy_q <= 1'b0;
                end
            end
            // copy page buffer into the array, one byte per cycle
            cp_v_q   <= cp_run_q;
            cp_idx_q <= cp_q[`EPW_PW-1:0];
            if (cp_run_q) begin
                cp_q <= cp_q + 5'h01;
                if (cp_q == `EPW_PAGE_END - 5'h01) begin
                    cp_run_q <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // protection bits: only reset by nv_rst, kept across rst
    // ----------------------------------------------------------------
    always @(posedge clk or posedge nv_rst) begin
        if (nv_rst) begin
            bp_q <= `EPW_BP_RESET;
        end else if (stat_go) begin
            bp_q <= wsr_val_q;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign so      = so_sh_q[7];
    assign so_oe_n = ~(active & ((st_q == ST_RDATA) | (st_q == ST_RSR)));
    assign standby = cs_q;
    assign write_enable_latch     = latch_q;
    assign write_in_progress      = busy_q;
    assign protect_level_high_bit = bp_q[1];
    assign protect_level_low_bit  = bp_q[0];

endmodule // epw_core

// ---- inc/epw_map.vh ----
`ifndef EPW_MAP_VH
`define EPW_MAP_VH

// ----------------------------------------------------------------
// opcodes (address bit 8 masked out of read and write)
// ----------------------------------------------------------------
`define EPW_OP_MASK      8'hF7
`define EPW_OP_READ      8'h03
`define EPW_OP_WRITE     8'h02
`define EPW_OP_WRDIS     8'h04
`define EPW_OP_SETL      8'h06
`define EPW_OP_RDSTAT    8'h05
`define EPW_OP_WRSTAT    8'h01
`define EPW_A8_BIT       3

// ----------------------------------------------------------------
// status byte layout
// ----------------------------------------------------------------
`define EPW_SR_BP_HI     3
`define EPW_SR_BP_LO     2
`define EPW_SR_LATCH     1
`define EPW_SR_BUSY      0
`define EPW_SR_UPPER     4'h0

// ----------------------------------------------------------------
// protection levels and boundaries
// ----------------------------------------------------------------
`define EPW_PROT_NONE    2'h0
`define EPW_PROT_QUART   2'h1
`define EPW_PROT_HALF    2'h2
`define EPW_PROT_ALL     2'h3
`define EPW_QUART_BASE   9'h180
`define EPW_HALF_BASE    9'h100
`define EPW_BP_RESET     2'h0

// ----------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------
`define EPW_AW           9
`define EPW_PW           4
`define EPW_DW           8
`define EPW_BIT_LAST     3'h7
`define EPW_BIT_FIRST    3'h0
`define EPW_PAGE_END     5'h10
`define EPW_CLK_NS       10
`define EPW_T_WRITE_NS   5000000
`define EPW_WC_W         20

`endif

// ---- design/epw_ram.v ----
`timescale 1ns/1ns

module epw_ram #(
    parameter AW = 9,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire          re,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_q
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // contents are not reset: they model stored cells
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= {DW{1'b0}};
        end else if (re) begin
            rdata_q <= mem[raddr];
        end
    end

endmodule // epw_ram

// ---- test/epw_core_checker.sv ----
`timescale 1ns/1ns

module epw_core_checker #(
    parameter int WRITE_CYCLES = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic nv_rst,
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic so_oe_n,
    input wire logic standby,
    input wire logic write_enable_latch,
    input wire logic write_in_progress,
    input wire logic protect_level_high_bit,
    input wire logic protect_level_low_bit
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // busy length counter
    // ----------------------------------------
    logic [19:0] busy_cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) busy_cnt_q <= 20'h0;
        else if (write_in_progress) busy_cnt_q <= busy_cnt_q + 20'h1;
        else busy_cnt_q <= 20'h0;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_idle_no_drive: assert property (standby |-> so_oe_n)
        else $error("output driven while in standby");
    a_drive_needs_sel: assert property (!so_oe_n |-> !$past(cs_n))
        else $error("output driven without select");
    a_select_quiet: assert property ($fell(standby) |-> so_oe_n [*8])
        else $error("output driven before a command");
    a_wp_clears: assert property (!wp_n |=> !write_enable_latch)
        else $error("latch not held clear under protect pin");
    a_latch_rise: assert property ($rose(write_enable_latch) |-> wp_n && standby)
        else $error("latch set outside a completed command");
    a_busy_start: assert property ($rose(write_in_progress) |-> write_enable_latch && wp_n)
        else $error("write started without enable");
    a_busy_end: assert property ($fell(write_in_progress) |-> ##[0:1] !write_enable_latch)
        else $error("latch not cleared after write");
    a_busy_length: assert property ($fell(write_in_progress) |->
        busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 17)
        else $error("write cycle length wrong");
    a_level_change: assert property (disable iff (rst || nv_rst)
        !$stable({protect_level_high_bit, protect_level_low_bit}) |-> $rose(write_in_progress))
        else $error("protection bits changed outside status write");
endmodule // epw_core_checker

bind epw_core epw_core_checker #(.WRITE_CYCLES(WRITE_CYCLES)) epw_core_checker_i (
    .clk(clk), .rst(rst), .nv_rst(nv_rst), .cs_n(cs_n), .wp_n(wp_n), .so_oe_n(so_oe_n),
    .standby(standby), .write_enable_latch(write_enable_latch),
    .write_in_progress(write_in_progress), .protect_level_high_bit(protect_level_high_bit),
    .protect_level_low_bit(protect_level_low_bit));

// ---- test/epw_spi_host.sv ----
`timescale 1ns/1ns

module epw_spi_host (
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic [7:0] r     = 8'h00;
    logic       last  = 1'b0;
    logic       drove = 1'b0;
    event       got;

    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    // one framed transfer; slow phases of 4 clk each
    task automatic xfer(input logic [31:0] d, input int n, input bit chk);
        int i;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (i = n - 1; i >= 0; i--) begin
            si = d[i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            // a floating line must not look like the last driven bit
            last  = so_oe_n ? ~last : so;
            drove = drove | !so_oe_n;
            r     = {r[6:0], last};
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        si   = ~si;
        repeat (8) @(negedge clk);
        if (chk) -> got;
    endtask
endmodule // epw_spi_host

// ---- test/tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb;
    localparam int WC = 600;
    logic clk = 1'b0, rst = 1'b1, nv_rst = 1'b1, wp_n = 1'b1;
    wire  cs_n, sck, si, so, so_oe_n, standby;
    wire  write_enable_latch, write_in_progress, protect_level_high_bit, protect_level_low_bit;
    int          n_fail = 0;
    int          check_count = 0;
    logic [15:0] expq[$];
    logic [15:0] note;
    logic [7:0]  mem[int];
    logic [8:0]  adr[6] = '{9'h000, 9'h0FF, 9'h100, 9'h17F, 9'h180, 9'h1FF};

    always #5 clk = ~clk;

    epw_core #(.WRITE_CYCLES(WC)) epw_core_i (
        .clk(clk), .rst(rst), .nv_rst(nv_rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
        .so(so), .so_oe_n(so_oe_n), .standby(standby), .write_enable_latch(write_enable_latch),
        .write_in_progress(write_in_progress), .protect_level_high_bit(protect_level_high_bit),
        .protect_level_low_bit(protect_level_low_bit));

    epw_spi_host host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));

    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(host_i.got) begin
        note = expq.pop_front();
        `CHK("read byte", note[7:0], host_i.r & note[15:8])
    end

    task automatic cmd(input logic [31:0] d, input int n);
        host_i.xfer(d, n, 1'b0);
    endtask

    task automatic rd(input logic [31:0] d, input int n, input logic [7:0] m, input logic [7:0] e);
        expq.push_back({m, e & m});
        host_i.xfer(d, n, 1'b1);
    endtask

    task automatic wait_idle;
        int k;
        for (k = 0; k < 2000 && write_in_progress !== 1'b0; k++) @(negedge clk);
        `CHK("idle", 1'b0, write_in_progress)
    endtask

    task finish_test;
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        // about twice the expected run length
        #600000;
        n_fail++;
        finish_test;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        logic [1:0] lv;
        bit         prot;
        int         i, l;
        void'($urandom(32'h1BFFBA1F));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        nv_rst = 1'b0;
        `CHK("standby", 1'b1, standby)
        `CHK("latch pin", 1'b0, write_enable_latch)
        rd(32'h0500, 16, 8'hFF, 8'h00);
        cmd(32'h06, 8);
        `CHK("latch pin", 1'b1, write_enable_latch)
        rd(32'h0500, 16, 8'hFF, 8'h02);
        cmd(32'h04, 8);
        rd(32'h0500, 16, 8'hFF, 8'h00);
        cmd(32'h0C, 9);
        rd(32'h0500, 16, 8'hFF, 8'h00);
        cmd(32'h010C, 16);
        rd(32'h0500, 16, 8'hFF, 8'h00);
        cmd(32'h06, 8);
        wp_n = 1'b0;
        rd(32'h0500, 16, 8'hFF, 8'h00);
        cmd(32'h06, 8);
        cmd(32'h010C, 16);
        rd(32'h0500, 16, 8'hFF, 8'h00);
        wp_n = 1'b1;
        for (l = 0; l < 4; l++) begin
            lv = l[1:0];
            cmd(32'h06, 8);
            cmd({16'h0, 8'h01, 4'($urandom), lv, 2'($urandom)}, 16);
            wait_idle;
            rd(32'h0500, 16, 8'hFF, {4'h0, lv, 2'h0});
            `CHK("level pins", lv, {protect_level_high_bit, protect_level_low_bit})
            for (i = 0; i < 6; i++) begin
                prot = lv == 2'h3 || (lv == 2'h2 && adr[i] >= 9'h100) || (lv == 2'h1 && adr[i] >= 9'h180);
                d = 8'($urandom);
                cmd(32'h06, 8);
                cmd({8'h0, 4'h0, adr[i][8], 3'h2, adr[i][7:0], d}, 24);
                rd(32'h0500, 16, 8'h01, {7'h0, !prot});
                if (!prot) begin
                    mem[adr[i]] = d;
                    host_i.drove = 1'b0;
                    cmd({8'h0, 4'h0, adr[i][8], 3'h3, adr[i][7:0], 8'h00}, 24);
                    `CHK("drive while busy", 1'b0, host_i.drove)
                end
                wait_idle;
                rd(32'h0500, 16, prot ? 8'hFD : 8'hFF, {4'h0, lv, 2'h0});
                rd({8'h0, 4'h0, adr[i][8], 3'h3, adr[i][7:0], 8'h00}, 24, 8'hFF, mem[adr[i]]);
            end
        end
        // level must survive a plain reset, the latch must not
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd(32'h0500, 16, 8'hFF, {4'h0, 2'h3, 2'h0});
        // let the watcher take the last note before the verdict
        repeat (2) @(negedge clk);
        `CHK("notes left", 0, expq.size())
        finish_test;
    end
endmodule // tb
